// *** rxwb_checker.sv ***
`timescale 1ns/1ns
module rxwb_checker
    import rxwb_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Frame result
    input wire logic info_valid_i,
    input wire rxwb_frame_info_t info_i,
    input wire logic ts_valid_i,
    input wire logic [63:0] ts_i,
    // Close request
    input wire logic close_valid_i,
    input wire logic [31:0] close_base_i,
    input wire logic [31:0] close_word0_i,
    input wire logic close_last_i,
    input wire logic close_ready_o,
    // Memory write
    input wire logic mem_wr_valid_o,
    input wire rxwb_mem_wr_t mem_wr_o,
    input wire logic mem_wr_ready_i,
    // Interrupt
    input wire logic irq_o
);
    logic take, acc, w4;
    logic [31:0] base_q, off;
    logic last_q, coe_q;
    logic [2:0] cnt_q;
    logic [63:0] ts_q;
    assign take = close_valid_i && close_ready_o;
    assign acc = mem_wr_valid_o && mem_wr_ready_i;
    assign w4 = acc && last_q && cnt_q == 3'h0;
    assign off = !last_q ? 32'h0 : cnt_q == 3'h0 ? 32'h10 : cnt_q == 3'h1 ? 32'h18 :
        cnt_q == 3'h2 ? 32'h1C : 32'h0;
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            base_q <= 32'h0;
            last_q <= 1'b0;
            cnt_q <= 3'h0;
        end else if (take) begin
            base_q <= close_base_i;
            last_q <= close_last_i;
            cnt_q <= 3'h0;
        end else if (acc) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ts_q <= 64'h0;
            coe_q <= 1'b0;
        end else begin
            if (ts_valid_i) ts_q <= ts_i;
            if (reg_wr_i && reg_addr_i == ADDR_W'(RXWB_CTRL_OFS)) coe_q <= reg_wdata_i[10];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    ready_busy_a: assert property (mem_wr_valid_o |-> !close_ready_o)
        else $error("close accepted while writing");
    last_busy_a: assert property (take && close_last_i |=> !close_ready_o [*7])
        else $error("last descriptor closed too fast");
    req_hold_a: assert property (mem_wr_valid_o && !mem_wr_ready_i |=>
        mem_wr_valid_o && $stable(mem_wr_o))
        else $error("write request changed before accept");
    word_addr_a: assert property (acc |-> mem_wr_o.addr == base_q + off)
        else $error("descriptor word order or address wrong");
    ts_low_a: assert property (acc && last_q && cnt_q == 3'h1 |->
        mem_wr_o.data == ts_q[31:0])
        else $error("timestamp low word wrong");
    ts_high_a: assert property (acc && last_q && cnt_q == 3'h2 |->
        mem_wr_o.data == ts_q[63:32])
        else $error("timestamp high word wrong");
    own_bits_a: assert property (acc && mem_wr_o.addr == base_q |->
        !mem_wr_o.data[31] && mem_wr_o.data[8] == last_q)
        else $error("word zero ownership or last bit wrong");
    msg_code_a: assert property (w4 |-> !(mem_wr_o.data[11:8] inside {[4'hB:4'hE]}))
        else $error("reserved message code written");
    proto_top_a: assert property (w4 |-> !mem_wr_o.data[2])
        else $error("reserved payload type written");
    hdr_zero_a: assert property (w4 && mem_wr_o.data[3] |-> mem_wr_o.data[2:0] == 3'h0)
        else $error("payload type kept after header error");
    ip_gate_a: assert property (w4 && !coe_q |-> mem_wr_o.data[7:6] == 2'h0)
        else $error("IP flags set with offload disabled");
endmodule // rxwb_checker
bind rxwb_top rxwb_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) rxwb_checker_i (.*);

// *** rxwb_ext_encode.sv ***
`timescale 1ns/1ns
module rxwb_ext_encode
    import rxwb_pkg::*;
(
    // Frame result and control
    input wire rxwb_frame_info_t info_i,
    input wire logic coe_enable_i,
    // Encoded extended status word
    output logic [31:0] ext_word_o,
    output logic ptp_rsv_o
);
    logic [3:0] msg;
    logic [2:0] proto;

    always_comb begin
        msg = RXWB_MSG_RESERVED;
        if (!info_i.ptp_present) begin
            msg = RXWB_MSG_NONE;
        end else begin
            case (info_i.ptp_raw_type)
                RXWB_RAW_SYNC: msg = RXWB_MSG_SYNC;
                RXWB_RAW_FOLLOW_UP: msg = RXWB_MSG_FOLLOW_UP;
                RXWB_RAW_DELAY_REQ: msg = RXWB_MSG_DELAY_REQ;
                RXWB_RAW_DELAY_RESP: msg = RXWB_MSG_DELAY_RESP;
                RXWB_RAW_PDELAY_REQ: msg = RXWB_MSG_PDELAY_REQ;
                RXWB_RAW_PDELAY_RESP: msg = RXWB_MSG_PDELAY_RESP;
                RXWB_RAW_PDELAY_FUP: msg = RXWB_MSG_PDELAY_FUP;
                RXWB_RAW_ANNOUNCE: msg = RXWB_MSG_ANNOUNCE;
                RXWB_RAW_MANAGEMENT: msg = RXWB_MSG_MANAGEMENT;
                RXWB_RAW_SIGNALING: msg = RXWB_MSG_SIGNALING;
                default: msg = RXWB_MSG_RESERVED;
            endcase
        end
    end

    always_comb begin
        proto = info_i.proto;
        if (info_i.hdr_csum_bad || info_i.version_mismatch || info_i.fragmented) begin
            proto = RXWB_PROTO_UNKNOWN;
        end
    end

    always_comb begin
        ext_word_o = 32'h0000_0000;
        ext_word_o[RXWB_EXT_MSG_LSB +: 4] = msg;
        ext_word_o[RXWB_EXT_IPV6_BIT] = coe_enable_i && info_i.is_ipv6;
        ext_word_o[RXWB_EXT_IPV4_BIT] = coe_enable_i && info_i.is_ipv4;
        ext_word_o[RXWB_EXT_BYP_BIT] = info_i.coe_bypassed;
        ext_word_o[RXWB_EXT_PAY_BIT] = info_i.payload_csum_bad || info_i.length_mismatch;
        ext_word_o[RXWB_EXT_HDR_BIT] = info_i.hdr_csum_bad || info_i.version_mismatch;
        ext_word_o[RXWB_EXT_PROTO_LSB +: 3] = proto;
    end

    assign ptp_rsv_o = (msg == RXWB_MSG_RESERVED);

endmodule // rxwb_ext_encode

// *** rxwb_host_mem.sv ***
`timescale 1ns/1ns
module rxwb_host_mem
    import rxwb_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Write port from the block
    input wire logic mem_wr_valid_i,
    input wire rxwb_mem_wr_t mem_wr_i,
    input wire logic slow_i,
    output logic mem_wr_ready_o
);
    logic [31:0] mem_q [0:255];
    logic [2:0] wait_q;
    // Never ready in the first valid cycle
    assign mem_wr_ready_o = mem_wr_valid_i && (wait_q >= (slow_i ? 3'h4 : 3'h1));
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem_q[i] = 32'hA5A5_0000 | i;
        end
    end
    always @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            wait_q <= 3'h0;
        end else if (mem_wr_ready_o) begin
            wait_q <= 3'h0;
            mem_q[mem_wr_i.addr[9:2]] <= mem_wr_i.data;
        end else if (mem_wr_valid_i && wait_q != 3'h7) begin
            wait_q <= wait_q + 3'h1;
        end
    end
endmodule // rxwb_host_mem

// *** rxwb_pkg.sv ***
package rxwb_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] RXWB_CTRL_OFS = 8'h00;
    localparam logic [7:0] RXWB_STATE_OFS = 8'h04;
    localparam logic [7:0] RXWB_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] RXWB_IRQ_CLR_OFS = 8'h0C;
    localparam logic [7:0] RXWB_IRQ_EN_OFS = 8'h10;
    localparam logic [7:0] RXWB_LAST_EXT_OFS = 8'h14;
    localparam logic [7:0] RXWB_FRAME_CNT_OFS = 8'h18;

    // Control register fields
    localparam int RXWB_CTRL_COE_BIT = 10;
    localparam logic [31:0] RXWB_CTRL_RESET = 32'h0000_0000;

    // Interrupt bits
    localparam int RXWB_IRQ_W = 4;
    localparam int RXWB_IRQ_DONE = 0;
    localparam int RXWB_IRQ_PAY_ERR = 1;
    localparam int RXWB_IRQ_HDR_ERR = 2;
    localparam int RXWB_IRQ_PTP_RSV = 3;

    // Descriptor word indexes
    localparam logic [2:0] RXWB_DESC_W0 = 3'h0;
    localparam logic [2:0] RXWB_DESC_W4 = 3'h4;
    localparam logic [2:0] RXWB_DESC_W6 = 3'h6;
    localparam logic [2:0] RXWB_DESC_W7 = 3'h7;

    // Word 0 fields
    localparam int RXWB_W0_OWN_BIT = 31;
    localparam int RXWB_W0_LAST_BIT = 8;

    // Extended status word fields
    localparam int RXWB_EXT_MSG_LSB = 8;
    localparam int RXWB_EXT_IPV6_BIT = 7;
    localparam int RXWB_EXT_IPV4_BIT = 6;
    localparam int RXWB_EXT_BYP_BIT = 5;
    localparam int RXWB_EXT_PAY_BIT = 4;
    localparam int RXWB_EXT_HDR_BIT = 3;
    localparam int RXWB_EXT_PROTO_LSB = 0;

    // Message type codes written to the descriptor
    localparam logic [3:0] RXWB_MSG_NONE = 4'h0;
    localparam logic [3:0] RXWB_MSG_SYNC = 4'h1;
    localparam logic [3:0] RXWB_MSG_FOLLOW_UP = 4'h2;
    localparam logic [3:0] RXWB_MSG_DELAY_REQ = 4'h3;
    localparam logic [3:0] RXWB_MSG_DELAY_RESP = 4'h4;
    localparam logic [3:0] RXWB_MSG_PDELAY_REQ = 4'h5;
    localparam logic [3:0] RXWB_MSG_PDELAY_RESP = 4'h6;
    localparam logic [3:0] RXWB_MSG_PDELAY_FUP = 4'h7;
    localparam logic [3:0] RXWB_MSG_ANNOUNCE = 4'h8;
    localparam logic [3:0] RXWB_MSG_MANAGEMENT = 4'h9;
    localparam logic [3:0] RXWB_MSG_SIGNALING = 4'hA;
    localparam logic [3:0] RXWB_MSG_RESERVED = 4'hF;

    // Raw PTP messageType values from the wire
    localparam logic [3:0] RXWB_RAW_SYNC = 4'h0;
    localparam logic [3:0] RXWB_RAW_DELAY_REQ = 4'h1;
    localparam logic [3:0] RXWB_RAW_PDELAY_REQ = 4'h2;
    localparam logic [3:0] RXWB_RAW_PDELAY_RESP = 4'h3;
    localparam logic [3:0] RXWB_RAW_FOLLOW_UP = 4'h8;
    localparam logic [3:0] RXWB_RAW_DELAY_RESP = 4'h9;
    localparam logic [3:0] RXWB_RAW_PDELAY_FUP = 4'hA;
    localparam logic [3:0] RXWB_RAW_ANNOUNCE = 4'hB;
    localparam logic [3:0] RXWB_RAW_SIGNALING = 4'hC;
    localparam logic [3:0] RXWB_RAW_MANAGEMENT = 4'hD;

    // Payload protocol codes
    typedef enum logic [2:0] {
        RXWB_PROTO_UNKNOWN = 3'h0,
        RXWB_PROTO_UDP = 3'h1,
        RXWB_PROTO_TCP = 3'h2,
        RXWB_PROTO_ICMP = 3'h3
    } rxwb_proto_t;

    // Per-frame parse result from the receive checksum engine and PTP parser
    typedef struct packed {
        logic ptp_present;
        logic [3:0] ptp_raw_type;
        logic is_ipv4;
        logic is_ipv6;
        logic coe_bypassed;
        logic payload_csum_bad;
        logic length_mismatch;
        logic hdr_csum_bad;
        logic version_mismatch;
        logic fragmented;
        rxwb_proto_t proto;
    } rxwb_frame_info_t;

    // Descriptor write toward host memory
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } rxwb_mem_wr_t;

    // Writeback sequencer states, Gray from IDLE through W4, W6 and W7 to W0
    typedef enum logic [2:0] {
        RXWB_ST_IDLE = 3'b000,
        RXWB_ST_W4 = 3'b001,
        RXWB_ST_W6 = 3'b011,
        RXWB_ST_W7 = 3'b010,
        RXWB_ST_W0 = 3'b110
    } rxwb_state_t;

endpackage

// *** rxwb_top.sv ***
`timescale 1ns/1ns
// Overview of operation
// - PTP message types coded one to ten
// - Zero without PTP, all ones reserved
// - IPv6 flag only with offload enabled
// - IPv4 flag only with offload enabled
// - Flag set when checksum engine bypassed
// - Payload error on checksum mismatch
// - Payload error on length mismatch
// - Payload error meaningful only with IP flag
// - Header error on checksum or version mismatch
// - Three-bit payload protocol code
// - Protocol forced zero on skipped payload
// - Timestamp low half into word six
// - Timestamp high half into word seven
// - Timestamp only in last descriptor
module rxwb_top
    import rxwb_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Frame result from checksum engine and PTP parser
    input wire logic info_valid_i,
    input wire rxwb_frame_info_t info_i,
    input wire logic ts_valid_i,
    input wire logic [63:0] ts_i,
    // Descriptor close request from the DMA
    input wire logic close_valid_i,
    input wire logic [31:0] close_base_i,
    input wire logic [31:0] close_word0_i,
    input wire logic close_last_i,
    output logic close_ready_o,
    // Descriptor write port toward host memory
    output logic mem_wr_valid_o,
    output rxwb_mem_wr_t mem_wr_o,
    input wire logic mem_wr_ready_i,
    // Interrupt
    output logic irq_o
);
    rxwb_state_t state_q;
    rxwb_state_t state_d;
    rxwb_frame_info_t info_q;
    logic [63:0] ts_q;
    logic [31:0] base_q;
    logic [31:0] word0_q;
    logic last_q;
    logic [31:0] ctrl_q;
    logic [RXWB_IRQ_W-1:0] irq_stat_q;
    logic [RXWB_IRQ_W-1:0] irq_en_q;
    logic [31:0] last_ext_q;
    logic [CNT_W-1:0] frame_cnt_q;
    logic [31:0] ext_word;
    logic ptp_rsv;
    logic coe_enable;
    logic accept_close;
    logic wr_done;
    logic [2:0] word_idx;
    logic [31:0] word_data;
    logic [31:0] base_sel;
    logic [31:0] word0_sel;
    logic last_sel;
    logic [RXWB_IRQ_W-1:0] irq_set;
    logic [RXWB_IRQ_W-1:0] irq_clr;
    logic [31:0] rdata_d;
    logic [ADDR_W-1:0] a_ctrl;
    logic [ADDR_W-1:0] a_state;
    logic [ADDR_W-1:0] a_irq_stat;
    logic [ADDR_W-1:0] a_irq_clr;
    logic [ADDR_W-1:0] a_irq_en;
    logic [ADDR_W-1:0] a_last_ext;
    logic [ADDR_W-1:0] a_frame_cnt;

    assign a_ctrl = ADDR_W'(RXWB_CTRL_OFS);
    assign a_state = ADDR_W'(RXWB_STATE_OFS);
    assign a_irq_stat = ADDR_W'(RXWB_IRQ_STAT_OFS);
    assign a_irq_clr = ADDR_W'(RXWB_IRQ_CLR_OFS);
    assign a_irq_en = ADDR_W'(RXWB_IRQ_EN_OFS);
    assign a_last_ext = ADDR_W'(RXWB_LAST_EXT_OFS);
    assign a_frame_cnt = ADDR_W'(RXWB_FRAME_CNT_OFS);

    assign coe_enable = ctrl_q[RXWB_CTRL_COE_BIT];

    // Extended status encoder
    rxwb_ext_encode u_encode (
        .info_i(info_q),
        .coe_enable_i(coe_enable),
        .ext_word_o(ext_word),
        .ptp_rsv_o(ptp_rsv)
    );

    // Handshakes
    assign close_ready_o = (state_q == RXWB_ST_IDLE);
    assign accept_close = close_valid_i && close_ready_o;
    assign wr_done = mem_wr_valid_o && mem_wr_ready_i;

    // Latch the latest frame result
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            info_q <= '0;
        end else if (info_valid_i) begin
            info_q <= info_i;
        end
    end

    // Latch the captured timestamp
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ts_q <= 64'h0000_0000_0000_0000;
        end else if (ts_valid_i) begin
            ts_q <= ts_i;
        end
    end

    // Latch the descriptor being closed
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            base_q <= 32'h0000_0000;
            word0_q <= 32'h0000_0000;
            last_q <= 1'b0;
        end else if (accept_close) begin
            base_q <= close_base_i;
            word0_q <= close_word0_i;
            last_q <= close_last_i;
        end
    end

    // Writeback sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            RXWB_ST_IDLE: begin
                if (accept_close) begin
                    state_d = close_last_i ? RXWB_ST_W4 : RXWB_ST_W0;
                end
            end
            RXWB_ST_W4: begin
                if (wr_done) begin
                    state_d = RXWB_ST_W6;
                end
            end
            RXWB_ST_W6: begin
                if (wr_done) begin
                    state_d = RXWB_ST_W7;
                end
            end
            RXWB_ST_W7: begin
                if (wr_done) begin
                    state_d = RXWB_ST_W0;
                end
            end
            RXWB_ST_W0: begin
                if (wr_done) begin
                    state_d = RXWB_ST_IDLE;
                end
            end
            default: state_d = RXWB_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= RXWB_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Descriptor context, straight from the request on the accepting edge
    assign base_sel = accept_close ? close_base_i : base_q;
    assign word0_sel = accept_close ? close_word0_i : word0_q;
    assign last_sel = accept_close ? close_last_i : last_q;

    // Word selection for the state being entered
    always_comb begin
        word_idx = RXWB_DESC_W0;
        word_data = word0_sel;
        case (state_d)
            RXWB_ST_W4: begin
                word_idx = RXWB_DESC_W4;
                word_data = ext_word;
            end
            RXWB_ST_W6: begin
                word_idx = RXWB_DESC_W6;
                word_data = ts_q[31:0];
            end
            RXWB_ST_W7: begin
                word_idx = RXWB_DESC_W7;
                word_data = ts_q[63:32];
            end
            RXWB_ST_W0: begin
                word_idx = RXWB_DESC_W0;
                word_data = word0_sel;
                word_data[RXWB_W0_OWN_BIT] = 1'b0;
                word_data[RXWB_W0_LAST_BIT] = last_sel;
            end
            default: begin
                word_idx = RXWB_DESC_W0;
                word_data = word0_sel;
            end
        endcase
    end

    // Memory write request register
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_wr_valid_o <= 1'b0;
            mem_wr_o <= '0;
        end else if (state_d != RXWB_ST_IDLE && (state_d != state_q || !mem_wr_valid_o)) begin
            // Address and data load together with valid, then hold
            mem_wr_valid_o <= 1'b1;
            mem_wr_o.addr <= base_sel + {27'h0, word_idx, 2'b00};
            mem_wr_o.data <= word_data;
        end else if (wr_done) begin
            mem_wr_valid_o <= 1'b0;
        end
    end

    // Control register
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q <= RXWB_CTRL_RESET;
        end else if (reg_wr_i && reg_addr_i == a_ctrl) begin
            ctrl_q <= 32'h0000_0000;
            ctrl_q[RXWB_CTRL_COE_BIT] <= reg_wdata_i[RXWB_CTRL_COE_BIT];
        end
    end

    // Last extended status and frame counter
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            last_ext_q <= 32'h0000_0000;
            frame_cnt_q <= '0;
        end else if (state_q == RXWB_ST_W4 && wr_done) begin
            last_ext_q <= ext_word;
            frame_cnt_q <= frame_cnt_q + 1'b1;
        end
    end

    // Interrupt events
    always_comb begin
        irq_set = '0;
        if (state_q == RXWB_ST_W0 && wr_done && last_q) begin
            irq_set[RXWB_IRQ_DONE] = 1'b1;
        end
        if (state_q == RXWB_ST_W4 && wr_done) begin
            irq_set[RXWB_IRQ_PAY_ERR] = ext_word[RXWB_EXT_PAY_BIT]
                && (ext_word[RXWB_EXT_IPV4_BIT] || ext_word[RXWB_EXT_IPV6_BIT]);
            irq_set[RXWB_IRQ_HDR_ERR] = ext_word[RXWB_EXT_HDR_BIT]
                && (ext_word[RXWB_EXT_IPV4_BIT] || ext_word[RXWB_EXT_IPV6_BIT]);
            irq_set[RXWB_IRQ_PTP_RSV] = ptp_rsv;
        end
    end

    assign irq_clr = (reg_wr_i && reg_addr_i == a_irq_clr) ?
        reg_wdata_i[RXWB_IRQ_W-1:0] : '0;

    // Sticky status, set wins over clear
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_en_q <= '0;
        end else if (reg_wr_i && reg_addr_i == a_irq_en) begin
            irq_en_q <= reg_wdata_i[RXWB_IRQ_W-1:0];
        end
    end

    assign irq_o = |(irq_stat_q & irq_en_q);

    // Read decode
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_addr_i == a_ctrl) begin
            rdata_d = ctrl_q;
        end else if (reg_addr_i == a_state) begin
            rdata_d[2:0] = state_q;
        end else if (reg_addr_i == a_irq_stat) begin
            rdata_d[RXWB_IRQ_W-1:0] = irq_stat_q;
        end else if (reg_addr_i == a_irq_en) begin
            rdata_d[RXWB_IRQ_W-1:0] = irq_en_q;
        end else if (reg_addr_i == a_last_ext) begin
            rdata_d = last_ext_q;
        end else if (reg_addr_i == a_frame_cnt) begin
            rdata_d[CNT_W-1:0] = frame_cnt_q;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

endmodule // rxwb_top

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    import rxwb_pkg::*;
    logic mclk_i, reset_i, reg_wr, reg_rd, info_valid, ts_valid, close_valid, close_last;
    logic slow, close_ready, mem_wr_valid, mem_wr_ready, irq, rx_checksum_offload_engine;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, close_base, close_word0, rd;
    rxwb_frame_info_t info, f;
    rxwb_mem_wr_t mem_wr;
    logic [63:0] ts;
    int errors, comparisons, cycles;
    rxwb_top #(.ADDR_W(8), .CNT_W(16)) rxwb_top_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .info_valid_i(info_valid), .info_i(info),
        .ts_valid_i(ts_valid), .ts_i(ts), .close_valid_i(close_valid),
        .close_base_i(close_base), .close_word0_i(close_word0), .close_last_i(close_last),
        .close_ready_o(close_ready), .mem_wr_valid_o(mem_wr_valid), .mem_wr_o(mem_wr),
        .mem_wr_ready_i(mem_wr_ready), .irq_o(irq));
    rxwb_host_mem rxwb_host_mem_i (.mclk_i(mclk_i), .reset_i(reset_i),
        .mem_wr_valid_i(mem_wr_valid), .mem_wr_i(mem_wr), .slow_i(slow),
        .mem_wr_ready_o(mem_wr_ready));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask
    task reg_read(input logic [7:0] a);
        @(posedge mclk_i);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk_i);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    function automatic logic [3:0] msg_code(input rxwb_frame_info_t x);
        logic [3:0] m;
        case (x.ptp_raw_type)
            4'h0: m = 4'h1;
            4'h8: m = 4'h2;
            4'h1: m = 4'h3;
            4'h9: m = 4'h4;
            4'h2: m = 4'h5;
            4'h3: m = 4'h6;
            4'hA: m = 4'h7;
            4'hB: m = 4'h8;
            4'hD: m = 4'h9;
            4'hC: m = 4'hA;
            default: m = 4'hF;
        endcase
        return x.ptp_present ? m : 4'h0;
    endfunction
    task frame(input logic [7:0] slot, input logic last);
        logic [31:0] w6, e, mask;
        w6 = rxwb_host_mem_i.mem_q[slot + 6];
        e = {20'h0, msg_code(f), rx_checksum_offload_engine & f.is_ipv6, rx_checksum_offload_engine & f.is_ipv4, f.coe_bypassed,
            f.payload_csum_bad | f.length_mismatch, f.hdr_csum_bad | f.version_mismatch,
            (f.hdr_csum_bad | f.version_mismatch | f.fragmented) ? 3'h0 : f.proto};
        mask = (e[7] | e[6]) ? 32'hFFFF_FFFF : 32'hFFFF_FFE0;
        @(posedge mclk_i);
        info_valid <= 1'b1;
        info <= f;
        ts_valid <= 1'b1;
        ts <= {24'h5A5A_C3, slot, ~slot, 24'h0F_1E2D} ^ cycles;
        @(posedge mclk_i);
        info_valid <= 1'b0;
        ts_valid <= 1'b0;
        close_valid <= 1'b1;
        close_base <= 32'(slot) << 2;
        close_word0 <= 32'h8000_0300;
        close_last <= last;
        @(posedge mclk_i);
        close_valid <= 1'b0;
        #1;
        for (int n = 0; n < 100 && close_ready !== 1'b1; n++) @(posedge mclk_i) #1;
        check({31'h0, close_ready}, 32'h1);
        check(rxwb_host_mem_i.mem_q[slot], 32'h0000_0200 | (32'(last) << 8));
        if (last) begin
            check(rxwb_host_mem_i.mem_q[slot + 4] & mask, e & mask);
            check(rxwb_host_mem_i.mem_q[slot + 6], ts[31:0]);
            check(rxwb_host_mem_i.mem_q[slot + 7], ts[63:32]);
        end else begin
            check(rxwb_host_mem_i.mem_q[slot + 6], w6);
        end
    endtask
    task t_regs;
        reg_read(RXWB_CTRL_OFS);
        check(rd, RXWB_CTRL_RESET);
        reg_read(RXWB_IRQ_EN_OFS);
        check(rd, 32'h0);
        reg_read(8'h1C);
        check(rd, 32'h0);
        reg_write(RXWB_CTRL_OFS, 32'h0000_0400);
        reg_read(RXWB_CTRL_OFS);
        check(rd, 32'h0000_0400);
        reg_write(RXWB_CTRL_OFS, 32'h0);
    endtask
    task t_ptp;
        rx_checksum_offload_engine = 1'b0;
        for (int i = 0; i < 17; i++) begin
            f = '0;
            f.ptp_present = i < 16;
            f.ptp_raw_type = 4'(i);
            frame(8'(i * 8), 1'b1);
        end
    endtask
    task t_ip;
        reg_write(RXWB_CTRL_OFS, 32'h0000_0400);
        rx_checksum_offload_engine = 1'b1;
        for (int i = 0; i < 9; i++) begin
            if (i == 8) begin
                reg_write(RXWB_CTRL_OFS, 32'h0);
                rx_checksum_offload_engine = 1'b0;
            end
            f = '0;
            f.is_ipv4 = i[0];
            f.is_ipv6 = !i[0];
            f.proto = rxwb_proto_t'(3'(1 + i % 3));
            f.payload_csum_bad = i == 1;
            f.length_mismatch = i == 2;
            f.hdr_csum_bad = i == 3;
            f.version_mismatch = i == 4;
            f.fragmented = i == 5;
            f.coe_bypassed = i == 6;
            frame(8'(136 + i * 8), 1'b1);
        end
        reg_write(RXWB_CTRL_OFS, 32'h0000_0400);
        rx_checksum_offload_engine = 1'b1;
    endtask
    task t_nonlast;
        f = '0;
        f.is_ipv4 = 1'b1;
        frame(8'd208, 1'b0);
        frame(8'd216, 1'b1);
    endtask
    task t_irq;
        reg_write(RXWB_IRQ_CLR_OFS, 32'hF);
        reg_write(RXWB_IRQ_EN_OFS, 32'h2);
        f = '0;
        f.is_ipv4 = 1'b1;
        f.payload_csum_bad = 1'b1;
        slow = 1'b1;
        frame(8'd224, 1'b1);
        slow = 1'b0;
        check({31'h0, irq}, 32'h1);
        reg_read(RXWB_IRQ_STAT_OFS);
        check(rd & 32'h3, 32'h3);
        reg_write(RXWB_IRQ_EN_OFS, 32'h0);
        #1 check({31'h0, irq}, 32'h0);
        reg_write(RXWB_IRQ_EN_OFS, 32'h2);
        #1 check({31'h0, irq}, 32'h1);
        reg_write(RXWB_IRQ_CLR_OFS, 32'hF);
        #1 check({31'h0, irq}, 32'h0);
        reg_read(RXWB_IRQ_STAT_OFS);
        check(rd, 32'h0);
        reg_read(RXWB_LAST_EXT_OFS);
        check(rd, 32'h0000_0050);
        reg_read(RXWB_FRAME_CNT_OFS);
        check(rd, 32'h0000_001C);
        reg_read(RXWB_STATE_OFS);
        check(rd, 32'h0);
    endtask
    initial begin
        {reg_wr, reg_rd, info_valid, ts_valid, close_valid, close_last, slow, rx_checksum_offload_engine} = '0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        close_base = 32'h0;
        close_word0 = 32'h0;
        info = '0;
        f = '0;
        ts = 64'h0;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        reset_i = 1'b1;
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_regs();
        t_ptp();
        t_ip();
        t_nonlast();
        t_irq();
        give_verdict();
    end
endmodule // tb_top
